// file: design/dea_array.sv
// Byte storage array with one-cycle registered read.
`timescale 1ns/1ns
module dea_array #(
  parameter int AW = 10
) (
  // Clock
  input wire logic clk,
  // Access port
  dea_mem_if.mem   mp
);
  logic [7:0] cells [2**AW];
  logic [7:0] rdata_r;

  // Nonvolatile contents are deliberately not cleared by reset.
  always_ff @(posedge clk) begin
    if (mp.wr_en) begin
      cells[mp.addr] <= mp.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (mp.rd_en) begin
      rdata_r <= cells[mp.addr];
    end
  end

  assign mp.rdata = rdata_r;
endmodule

// file: design/dea_mem_if.sv
// Interface carrying the byte access requests between the control logic and the storage array.
`timescale 1ns/1ns
interface dea_mem_if #(parameter int AW = 10);
  logic          rd_en;
  logic          wr_en;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport ctl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// file: design/dea_pkg.sv
// Package holding register offsets, field positions, keys and timing counts for the data memory access block.
package dea_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h00;
  localparam logic [7:0] OFF_ADDR_LOW  = 8'h04;
  localparam logic [7:0] OFF_DATA      = 8'h08;
  localparam logic [7:0] OFF_KEY_PORT  = 8'h0C;
  localparam logic [7:0] OFF_CONTROL   = 8'h10;
  localparam logic [7:0] OFF_PRIORITY  = 8'h14;
  localparam logic [7:0] OFF_FLAGS     = 8'h18;
  localparam logic [7:0] OFF_ENABLES   = 8'h1C;
  localparam logic [7:0] OFF_PROT_CFG  = 8'h20;

  // ----------------------------------------------------------------
  // Control and flag register fields
  // ----------------------------------------------------------------
  localparam int CTL_READ_START  = 0;
  localparam int CTL_WRITE_START = 1;
  localparam int CTL_PERMIT      = 2;
  localparam int CTL_ERROR       = 3;
  localparam int CTL_ROW_ERASE   = 4;
  localparam int CTL_CFG_SPACE   = 6;
  localparam int CTL_PROG_SPACE  = 7;
  localparam logic [7:0] CTL_WMASK = 8'hDD;
  localparam int FLAG_WRITE_DONE = 4;
  localparam logic [7:0] FLG_WMASK = 8'hDF;

  // ----------------------------------------------------------------
  // Keys and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int CLK_MHZ            = 250;
  localparam int WRITE_TIME_US      = 4;
  localparam int POWERUP_TIME_US    = 66;
  localparam int WRITE_CYCLES       = WRITE_TIME_US * CLK_MHZ;
  localparam int POWERUP_CYCLES     = POWERUP_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT1 = 2'b01,
    KEY_GOT2 = 2'b10
  } dea_key_e;

endpackage

// file: design/dea_top.sv
// Data memory access control block with APB register slave.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: Write starts only after keys 55h, AAh then write start bit.
// RULE2: Write start bit stays set during write, cleared by hardware at end.
// RULE3: Write done flag set at completion; software then clears write permit.
// RULE4: Software loads address, data, clears space selects, sets permit before keys.
// RULE5: Software reads by loading address, clearing selects, setting read start.
// RULE6: External programming access refused while protect bit is set.
// RULE7: Internal processor access ignores the protect bit.
// RULE8: Write permit is clear after power up.
// RULE9: Writes blocked while the power-up timer still runs.
// RULE10: Key port stores nothing and reads as zero.
// RULE11: Full low address byte plus implemented high bits form the address.
// RULE12: Unimplemented address-high and control bits read zero, ignore writes.
// RULE13: Software refresh loop walks all addresses, reading and rewriting.
// RULE14: Software may read back each written byte to verify it.
// RULE15: Write start needs permit already set by an earlier write.
// RULE16: Control, address and data are frozen during a write.
// RULE17: Read start loads data next cycle and self clears; here the data register loads two cycles after read start is set.
// RULE18: Error flag set on interrupted or improper write; selects kept.
// RULE19: Key tracker returns idle on any write breaking the sequence.
module dea_top #(
  parameter int AW             = 10,
  parameter int WRITE_CYCLES   = dea_pkg::WRITE_CYCLES,
  parameter int POWERUP_CYCLES = dea_pkg::POWERUP_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        por,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External programming port
  input  wire logic        ext_rd,
  input  wire logic        ext_wr,
  input  wire logic [AW-1:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  output logic      [7:0]  ext_rdata,
  output logic             ext_refused,
  // Status
  output logic             write_busy
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (AW < 9 || AW > 16) begin : g_bad_aw
    $error("Address width must be 9 to 16");
  end
  if (WRITE_CYCLES < 2 || POWERUP_CYCLES < 1) begin : g_bad_cnt
    $error("Timing counts too small");
  end

  localparam int HW = AW - 8;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef dea_pkg::dea_key_e dea_key_e_t;

  logic [HW-1:0] addr_high_r;
  logic [7:0]    addr_low_r;
  logic [7:0]    data_r;
  logic          prog_space_select_r;
  logic          config_space_select_r;
  logic          row_erase_r;
  logic          write_error_flag_r;
  logic          write_permit_r;
  logic          write_start_r;
  logic          read_start_r;
  logic [7:0]    priority_r;
  logic [7:0]    flags_r;
  logic [7:0]    enables_r;
  logic          protect_r;
  dea_key_e_t    key_r;
  logic [31:0]   wcnt_r;
  logic [31:0]   pucnt_r;
  logic          rd_pend_r;
  logic          ext_rd_pend_r;
  logic          ext_refused_r;

  logic          wr_acc;
  logic          busy;
  logic          powerup_done;
  logic          start_ok;
  logic          write_end;
  logic          ext_ok;
  logic [AW-1:0] cpu_addr;

  dea_mem_if #(.AW(AW)) mif ();

  dea_array #(.AW(AW)) u_array (
    .clk (clk),
    .mp  (mif.mem)
  );

  assign wr_acc       = psel && penable && pwrite;
  assign busy         = write_start_r;
  assign powerup_done = (pucnt_r == 32'h0000_0000);
  assign write_end    = busy && (wcnt_r == 32'h0000_0001);
  assign cpu_addr     = {addr_high_r, addr_low_r}; // RULE11
  assign pready       = 1'b1;
  assign pslverr      = 1'b0;
  assign write_busy   = busy;

  // ----------------------------------------------------------------
  // Power-up timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (por) begin
      pucnt_r <= 32'(POWERUP_CYCLES);
    end else if (!powerup_done) begin
      pucnt_r <= pucnt_r - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Key sequence tracker
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || por) begin
      key_r <= dea_pkg::KEY_IDLE;
    end else if (wr_acc) begin
      if (paddr == dea_pkg::OFF_KEY_PORT && pwdata[7:0] == dea_pkg::KEY_FIRST) begin
        key_r <= dea_pkg::KEY_GOT1; // RULE19
      end else if (paddr == dea_pkg::OFF_KEY_PORT && pwdata[7:0] == dea_pkg::KEY_SECOND
                   && key_r == dea_pkg::KEY_GOT1) begin
        key_r <= dea_pkg::KEY_GOT2;
      end else begin
        key_r <= dea_pkg::KEY_IDLE; // RULE19
      end
    end
  end

  // The start is honoured only with both keys in order, permit held from before, and power settled.
  assign start_ok = wr_acc && paddr == dea_pkg::OFF_CONTROL && pwdata[dea_pkg::CTL_WRITE_START]
                    && !busy && key_r == dea_pkg::KEY_GOT2 && write_permit_r // RULE1 RULE15
                    && powerup_done && !prog_space_select_r && !config_space_select_r; // RULE9

  // ----------------------------------------------------------------
  // Write timer and write start bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || por) begin
      write_start_r <= 1'b0;
      wcnt_r        <= 32'h0000_0000;
    end else if (start_ok) begin
      write_start_r <= 1'b1;
      wcnt_r        <= 32'(WRITE_CYCLES);
    end else if (write_end) begin
      write_start_r <= 1'b0; // RULE2
      wcnt_r        <= 32'h0000_0000;
    end else if (busy) begin
      wcnt_r        <= wcnt_r - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (por) begin
      prog_space_select_r   <= 1'b0;
      config_space_select_r <= 1'b0;
      row_erase_r           <= 1'b0;
      write_permit_r        <= 1'b0; // RULE8
    end else if (rst) begin
      row_erase_r           <= 1'b0;
      write_permit_r        <= 1'b0;
    end else if (wr_acc && paddr == dea_pkg::OFF_CONTROL && !busy) begin // RULE16 RULE12
      prog_space_select_r   <= pwdata[dea_pkg::CTL_PROG_SPACE];
      config_space_select_r <= pwdata[dea_pkg::CTL_CFG_SPACE];
      row_erase_r           <= pwdata[dea_pkg::CTL_ROW_ERASE];
      write_permit_r        <= pwdata[dea_pkg::CTL_PERMIT];
    end
  end

  // The error flag survives a plain reset so software can see the aborted write.
  always_ff @(posedge clk) begin
    if (por) begin
      write_error_flag_r <= 1'b0;
    end else if (rst) begin
      write_error_flag_r <= write_error_flag_r | busy; // RULE18
    end else if (wr_acc && paddr == dea_pkg::OFF_CONTROL && pwdata[dea_pkg::CTL_WRITE_START]
                 && !busy && !start_ok) begin
      write_error_flag_r <= 1'b1; // RULE18
    end else if (wr_acc && paddr == dea_pkg::OFF_CONTROL && !busy) begin
      write_error_flag_r <= pwdata[dea_pkg::CTL_ERROR];
    end
  end

  // ----------------------------------------------------------------
  // Read start and data register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || por) begin
      read_start_r <= 1'b0;
      rd_pend_r    <= 1'b0;
    end else begin
      read_start_r <= wr_acc && paddr == dea_pkg::OFF_CONTROL && !busy
                      && pwdata[dea_pkg::CTL_READ_START] && !pwdata[dea_pkg::CTL_PROG_SPACE];
      rd_pend_r    <= read_start_r; // RULE17
    end
  end

  always_ff @(posedge clk) begin
    if (rst || por) begin
      addr_high_r <= '0;
      addr_low_r  <= 8'h00;
      data_r      <= 8'h00;
    end else begin
      // A back-to-back address write can land in the cycle the read data returns, so it must not wait behind it.
      if (wr_acc && !busy && paddr == dea_pkg::OFF_ADDR_HIGH) begin // RULE16
        addr_high_r <= pwdata[HW-1:0]; // RULE12
      end
      if (wr_acc && !busy && paddr == dea_pkg::OFF_ADDR_LOW) begin // RULE16
        addr_low_r <= pwdata[7:0];
      end
      if (rd_pend_r) begin
        data_r <= mif.rdata; // RULE17
      end else if (wr_acc && !busy && paddr == dea_pkg::OFF_DATA) begin // RULE16
        data_r <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag, enable, priority and protect registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || por) begin
      flags_r <= 8'h00;
    end else begin
      if (wr_acc && paddr == dea_pkg::OFF_FLAGS) begin
        flags_r <= pwdata[7:0] & dea_pkg::FLG_WMASK;
      end
      if (write_end) begin
        flags_r[dea_pkg::FLAG_WRITE_DONE] <= 1'b1; // RULE3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || por) begin
      enables_r  <= 8'h00;
      priority_r <= 8'h00;
      protect_r  <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == dea_pkg::OFF_ENABLES) begin
        enables_r <= pwdata[7:0] & dea_pkg::FLG_WMASK;
      end
      if (paddr == dea_pkg::OFF_PRIORITY) begin
        priority_r <= pwdata[7:0] & dea_pkg::FLG_WMASK;
      end
      if (paddr == dea_pkg::OFF_PROT_CFG) begin
        protect_r <= pwdata[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Array access arbitration
  // ----------------------------------------------------------------
  // External accesses wait behind the processor; protection gates only them.
  assign ext_ok      = !protect_r && !busy && !read_start_r && !rd_pend_r; // RULE6 RULE7
  assign mif.rd_en   = read_start_r || (ext_rd && ext_ok);
  assign mif.wr_en   = write_end || (ext_wr && ext_ok && powerup_done); // RULE9
  assign mif.addr    = (busy || read_start_r) ? cpu_addr : ext_addr;
  assign mif.wdata   = busy ? data_r : ext_wdata;

  always_ff @(posedge clk) begin
    if (rst || por) begin
      ext_rd_pend_r <= 1'b0;
      ext_refused_r <= 1'b0;
      ext_rdata     <= 8'h00;
    end else begin
      ext_rd_pend_r <= ext_rd && ext_ok;
      ext_refused_r <= (ext_rd || ext_wr) && protect_r; // RULE6
      if (ext_rd_pend_r) begin
        ext_rdata <= mif.rdata;
      end
    end
  end
  assign ext_refused = ext_refused_r;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      dea_pkg::OFF_ADDR_HIGH: prdata[HW-1:0] = addr_high_r;
      dea_pkg::OFF_ADDR_LOW:  prdata[7:0] = addr_low_r;
      dea_pkg::OFF_DATA:      prdata[7:0] = data_r;
      dea_pkg::OFF_CONTROL:   prdata[7:0] = {prog_space_select_r, config_space_select_r, 1'b0, row_erase_r,
                                             write_error_flag_r, write_permit_r, write_start_r, read_start_r};
      dea_pkg::OFF_PRIORITY:  prdata[7:0] = priority_r;
      dea_pkg::OFF_FLAGS:     prdata[7:0] = flags_r;
      dea_pkg::OFF_ENABLES:   prdata[7:0] = enables_r;
      dea_pkg::OFF_PROT_CFG:  prdata[0] = protect_r;
      default:                prdata = 32'h0000_0000; // RULE10
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_start_needs_keys: assert property (@(posedge clk) disable iff (rst || por) // RULE1
    $rose(write_start_r) |-> $past(key_r) == dea_pkg::KEY_GOT2 && $past(write_permit_r))
    else $error("write started without full key sequence");
  a_busy_holds: assert property (@(posedge clk) disable iff (rst || por) // RULE2
    start_ok |=> write_start_r [*2])
    else $error("write start bit dropped early");
  a_done_flag: assert property (@(posedge clk) disable iff (rst || por) // RULE3
    write_end |=> flags_r[dea_pkg::FLAG_WRITE_DONE] && !write_start_r)
    else $error("done flag not set at write end");
  a_ext_protect: assert property (@(posedge clk) disable iff (rst || por) // RULE6
    protect_r |-> !(mif.wr_en && !busy) && !(mif.rd_en && !read_start_r))
    else $error("external access passed while protected");
  a_powerup_block: assert property (@(posedge clk) disable iff (rst || por) // RULE9
    !powerup_done |-> !mif.wr_en)
    else $error("write during power-up time");
  a_frozen_regs: assert property (@(posedge clk) disable iff (rst || por) // RULE16
    busy && !write_end |=> $stable(cpu_addr) && $stable(write_permit_r))
    else $error("registers changed during write");
  a_read_data: assert property (@(posedge clk) disable iff (rst || por) // RULE17
    read_start_r |=> ##1 data_r == mif.rdata && !read_start_r)
    else $error("read data not loaded");
  a_key_break: assert property (@(posedge clk) disable iff (rst || por) // RULE19
    wr_acc && paddr != dea_pkg::OFF_KEY_PORT |=> key_r == dea_pkg::KEY_IDLE)
    else $error("key tracker not reset");
  c_write_done: cover property (@(posedge clk) write_end);
  c_read: cover property (@(posedge clk) rd_pend_r);
  c_refused: cover property (@(posedge clk) ext_refused_r);
endmodule

// file: verif/dea_top_tb.sv
// Self-checking testbench for the data memory access control block.
`timescale 1ns/1ns
module dea_top_tb;
  // ----------------------------------------------------------------
  // Clock, reset and design ports
  // ----------------------------------------------------------------
  localparam int AW     = 10;
  localparam int WR_CYC = 12;
  localparam int PU_CYC = 40;
  logic          clk       = 1'b0;
  logic          rst       = 1'b1;
  logic          por       = 1'b1;
  logic          psel      = 1'b0;
  logic          penable   = 1'b0;
  logic          pwrite    = 1'b0;
  logic [7:0]    paddr     = 8'h00;
  logic [31:0]   pwdata    = 32'h0000_0000;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          ext_rd    = 1'b0;
  logic          ext_wr    = 1'b0;
  logic [AW-1:0] ext_addr  = 10'h000;
  logic [7:0]    ext_wdata = 8'h00;
  logic [7:0]    ext_rdata;
  logic          ext_refused;
  logic          write_busy;
  int            mismatches  = 0;
  int            checks_done = 0;

  always #2 clk = ~clk;

  // Short write and power-up counts keep the run brief.
  dea_top #(.AW(AW), .WRITE_CYCLES(WR_CYC), .POWERUP_CYCLES(PU_CYC)) uut (
    .clk(clk), .rst(rst), .por(por), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .ext_refused(ext_refused), .write_busy(write_busy)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready, response and read data are all taken at the rising edge that ends the access phase.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int   n;
    logic rdy;
    logic err;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      q   = prdata;
      rdy = pready;
      err = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no ready", $time);
    end
    if (err !== 1'b0) begin
      mismatches++;
      $display("unexpected at %0t: error response", $time);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask

  task automatic busy_chk(input logic e);
    @(negedge clk);
    chk({31'h0000_0000, write_busy}, {31'h0000_0000, e});
  endtask

  task automatic do_write(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d);
    wr(dea_pkg::OFF_ADDR_HIGH, hi);
    wr(dea_pkg::OFF_ADDR_LOW, lo);
    wr(dea_pkg::OFF_DATA, d);
    wr(dea_pkg::OFF_CONTROL, 8'h04);
    wr(dea_pkg::OFF_KEY_PORT, dea_pkg::KEY_FIRST);
    wr(dea_pkg::OFF_KEY_PORT, dea_pkg::KEY_SECOND);
    wr(dea_pkg::OFF_CONTROL, 8'h06);
  endtask

  // Clears the data register first so the compare proves the array was read.
  task automatic rd_mem(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e);
    wr(dea_pkg::OFF_ADDR_HIGH, hi);
    wr(dea_pkg::OFF_ADDR_LOW, lo);
    wr(dea_pkg::OFF_DATA, 8'h00);
    wr(dea_pkg::OFF_CONTROL, 8'h01);
    rd_chk(dea_pkg::OFF_DATA, e);
    rd_chk(dea_pkg::OFF_CONTROL, 8'h00);
  endtask

  // Counts the falling edges until the write start bit drops; e is the count still expected.
  task automatic wait_idle(input int e);
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n, e);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk(dea_pkg::OFF_CONTROL, 8'h00);
    wr(dea_pkg::OFF_ADDR_HIGH, 8'hFF);
    rd_chk(dea_pkg::OFF_ADDR_HIGH, 8'h03);
    wr(dea_pkg::OFF_CONTROL, 8'h20);
    rd_chk(dea_pkg::OFF_CONTROL, 8'h00);
    wr(dea_pkg::OFF_KEY_PORT, dea_pkg::KEY_FIRST);
    rd_chk(dea_pkg::OFF_KEY_PORT, 8'h00);
    rd_chk(8'h24, 8'h00);
    wr(dea_pkg::OFF_ENABLES, 8'hFF);
    rd_chk(dea_pkg::OFF_ENABLES, 8'hDF);
    wr(dea_pkg::OFF_PRIORITY, 8'hFF);
    rd_chk(dea_pkg::OFF_PRIORITY, 8'hDF);
  endtask

  task automatic t_write();
    do_write(8'h01, 8'h23, 8'hA5);
    busy_chk(1'b1);
    wr(dea_pkg::OFF_DATA, 8'h00);
    wr(dea_pkg::OFF_ADDR_LOW, 8'h77);
    rd_chk(dea_pkg::OFF_CONTROL, 8'h06);
    rd_chk(dea_pkg::OFF_ADDR_LOW, 8'h23);
    // The busy check and four transfers use up all edges of the write but one.
    wait_idle(WR_CYC - 11);
    rd_chk(dea_pkg::OFF_FLAGS, 8'h10);
    rd_chk(dea_pkg::OFF_CONTROL, 8'h04);
    wr(dea_pkg::OFF_FLAGS, 8'h00);
    rd_chk(dea_pkg::OFF_FLAGS, 8'h00);
    wr(dea_pkg::OFF_CONTROL, 8'h00);
    rd_mem(8'h01, 8'h23, 8'hA5);
  endtask

  task automatic try_start(input logic [7:0] pre, input logic [7:0] k1, input logic [7:0] k2,
                           input logic [7:0] ctl, input logic brk);
    wr(dea_pkg::OFF_CONTROL, 8'h00);
    wr(dea_pkg::OFF_CONTROL, pre);
    wr(dea_pkg::OFF_KEY_PORT, k1);
    if (brk) begin
      wr(dea_pkg::OFF_ADDR_LOW, 8'h23);
    end
    wr(dea_pkg::OFF_KEY_PORT, k2);
    wr(dea_pkg::OFF_CONTROL, ctl);
    busy_chk(1'b0);
    rd_chk(dea_pkg::OFF_CONTROL, (ctl & 8'hFD) | 8'h08);
  endtask

  task automatic ext_chk(input logic w, input logic prot, input logic eref, input logic [7:0] ed);
    wr(dea_pkg::OFF_PROT_CFG, {7'h00, prot});
    @(posedge clk);
    ext_rd    <= ~w;
    ext_wr    <= w;
    ext_addr  <= 10'h123;
    ext_wdata <= 8'hFF;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0000_0000, ext_refused}, {31'h0000_0000, eref});
    if (!w && !eref) begin
      chk({24'h00_0000, ext_rdata}, {24'h00_0000, ed});
    end
    @(posedge clk);
    ext_rd <= 1'b0;
    ext_wr <= 1'b0;
  endtask

  // One step of a refresh: read into the data register, then rewrite it from there.
  task automatic t_refresh(input logic [7:0] lo, input logic [7:0] e);
    wr(dea_pkg::OFF_FLAGS, 8'h00);
    wr(dea_pkg::OFF_DATA, 8'h00);
    wr(dea_pkg::OFF_ADDR_LOW, lo);
    wr(dea_pkg::OFF_CONTROL, 8'h04);
    wr(dea_pkg::OFF_CONTROL, 8'h05);
    wr(dea_pkg::OFF_KEY_PORT, dea_pkg::KEY_FIRST);
    wr(dea_pkg::OFF_KEY_PORT, dea_pkg::KEY_SECOND);
    wr(dea_pkg::OFF_CONTROL, 8'h06);
    busy_chk(1'b1);
    wait_idle(WR_CYC);
    rd_chk(dea_pkg::OFF_FLAGS, 8'h10);
    rd_mem(8'h01, lo, e);
  endtask

  // A plain reset in mid-write must abort it, flag the error and leave the array untouched.
  task automatic t_abort();
    do_write(8'h01, 8'h23, 8'hC3);
    busy_chk(1'b1);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_chk(dea_pkg::OFF_CONTROL, 8'h08);
    rd_mem(8'h01, 8'h23, 8'h5A);
  endtask

  task automatic t_powerup();
    wr(dea_pkg::OFF_CONTROL, 8'h04);
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    rd_chk(dea_pkg::OFF_CONTROL, 8'h00);
    do_write(8'h01, 8'h23, 8'h3C);
    busy_chk(1'b0);
    repeat (PU_CYC) @(posedge clk);
    rd_mem(8'hFD, 8'h23, 8'h5A);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_regs();
    repeat (PU_CYC) @(posedge clk);
    t_write();
    try_start(8'h04, dea_pkg::KEY_SECOND, dea_pkg::KEY_FIRST, 8'h06, 1'b0);
    try_start(8'h04, dea_pkg::KEY_FIRST, 8'hAB, 8'h06, 1'b0);
    try_start(8'h00, dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND, 8'h06, 1'b0);
    try_start(8'h04, dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND, 8'h06, 1'b1);
    try_start(8'h84, dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND, 8'h86, 1'b0);
    wr(dea_pkg::OFF_CONTROL, 8'h00);
    ext_chk(1'b0, 1'b0, 1'b0, 8'hA5);
    ext_chk(1'b0, 1'b1, 1'b1, 8'h00);
    ext_chk(1'b1, 1'b1, 1'b1, 8'h00);
    rd_mem(8'h01, 8'h23, 8'hA5);
    do_write(8'h01, 8'h23, 8'h5A);
    busy_chk(1'b1);
    wait_idle(WR_CYC);
    rd_mem(8'h01, 8'h23, 8'h5A);
    t_refresh(8'h23, 8'h5A);
    t_abort();
    t_powerup();
    final_report();
  end

  // The whole run needs several hundred cycles; this span leaves ample margin.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule
